// ===== core/ssp_core.sv
// Serial port core: registers, SPI engine and I2C register set.
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ssp_core (
  input wire logic clk,           // 40 MHz system clock.
  input wire logic sys_rst,       // Synchronous active-high reset.
  input wire logic wb_cyc_i,      // Wishbone cycle.
  input wire logic wb_stb_i,      // Wishbone strobe.
  input wire logic wb_we_i,       // Wishbone write enable.
  input wire logic [4:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o,   // Wishbone read data.
  output logic wb_ack_o,          // Wishbone acknowledge.
  output logic wb_err_o,          // Wishbone error for unmapped address.
  input wire logic sck_i,         // Serial clock in (slave mode).
  output logic sck_o,             // Serial clock out (master mode).
  output logic sck_oe,            // Serial clock drive enable.
  input wire logic sdi_i,         // Serial data in.
  output logic sdo_o,             // Serial data out.
  input wire logic ss_n_i,        // Slave select, active low.
  output logic wake_o             // Wake request to the processor.
);
  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_RUN = 3'b010,
    SSP_DONE = 3'b100
  } ssp_state_t;

  typedef struct packed {
    ssp_state_t st;
    logic [7:0] buf_q;
    logic [7:0] con1;
    logic [7:0] con2;
    logic [1:0] stat_hi;
    logic bf;
    logic [7:0] addr;
    logic sleep;
    logic irq_flag;
    logic irq_en;
    logic sck;
    logic sck_prev;
    logic [1:0] div;
    logic sdo;
    logic [31:0] rdat;
    logic ack;
    logic err;
    logic wake;
  } ssp_regs_t;

  ssp_regs_t r_reg;
  ssp_regs_t r_next;
  logic [7:0] shift_data;
  logic shift_done;
  logic shift_edge;
  logic sample_edge;
  logic load;
  logic clr;
  logic req;
  logic wr;
  logic rd;
  logic busy;
  logic master;
  logic slave;
  logic en;
  logic sck_view;

  // Byte lane zero write enable; registers are eight bits wide.
  function automatic logic lane0(input logic [3:0] sel);
    lane0 = sel[0];
  endfunction : lane0

  // ----------------------------------------------------------------------
  // Mode decode and edge selection.
  // ----------------------------------------------------------------------
  // Master drives its own clock; slave follows the external clock pin.
  assign en = r_reg.con1[ssp_pkg::CON1_EN];
  assign master = en && (r_reg.con1[3:0] == ssp_pkg::MODE_SPI_MASTER);
  assign slave = en && (r_reg.con1[3:0] == ssp_pkg::MODE_SPI_SLAVE);
  assign busy = (r_reg.st == SSP_RUN);
  assign sck_view = master ? r_reg.sck : sck_i;
  assign req = wb_cyc_i && wb_stb_i && !r_reg.ack && !r_reg.err;
  assign wr = req && wb_we_i && lane0(wb_sel_i);
  assign rd = req && !wb_we_i;

  // Edge choice by polarity and edge bit.
  ssp_edge u_edge (
    .sck_now(sck_view),
    .sck_prev(r_reg.sck_prev),
    .pol(r_reg.con1[ssp_pkg::CON1_CKP]),
    .cke(r_reg.stat_hi[0]),
    .shift_edge(shift_edge),
    .sample_edge(sample_edge)
  );

  // Write outside a transfer, with the port enabled, loads buffer and shifter together.
  assign load = wr && (wb_adr_i[3:0] == ssp_pkg::ADDR_BUFFER)
    && (wb_adr_i[4] == 1'b0) && !busy && en;
  // Reset, disable or deselected slave aborts the transfer.
  assign clr = sys_rst || !en || (slave && ss_n_i);

  // Slave edges come from the pin even while asleep.
  ssp_shift u_shift (
    .clk(clk),
    .clr(clr),
    .load(load),
    .load_val(wb_dat_i[7:0]),
    .sample(sample_edge && (slave || (master && !r_reg.sleep))),
    .sdi(sdi_i),
    .data(shift_data),
    .done(shift_done)
  );

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.err = 1'b0;
    // A master edge that lands as sleep begins stays pending until wake.
    if (!(master && r_reg.sleep))
    begin
      r_next.sck_prev = sck_view;
    end
    // Bus answer one cycle after the request; unmapped gets err.
    if (req)
    begin
      r_next.rdat = 32'h0000_0000;
      if (wb_adr_i == {1'b0, ssp_pkg::ADDR_BUFFER})
      begin
        r_next.rdat[7:0] = r_reg.buf_q;
        r_next.ack = 1'b1;
        if (rd)
        begin
          r_next.bf = 1'b0;
        end
        if (wr && busy)
        begin
          r_next.con1[ssp_pkg::CON1_WRITE_COLLISION] = 1'b1;
        end
        else if (load)
        begin
          r_next.buf_q = wb_dat_i[7:0];
        end
      end
      else if (wb_adr_i == {1'b0, ssp_pkg::ADDR_CONTROL_ONE})
      begin
        r_next.rdat[7:0] = r_reg.con1;
        r_next.ack = 1'b1;
        if (wr)
        begin
          r_next.con1 = wb_dat_i[7:0];
        end
      end
      else if (wb_adr_i == {1'b0, ssp_pkg::ADDR_STATUS})
      begin
        r_next.rdat[7:0] = {r_reg.stat_hi, 5'h00, r_reg.bf};
        r_next.ack = 1'b1;
        if (wr)
        begin
          r_next.stat_hi = wb_dat_i[7:6];
        end
      end
      else if (wb_adr_i == {1'b0, ssp_pkg::ADDR_CONTROL_TWO})
      begin
        r_next.rdat[7:0] = r_reg.con2;
        r_next.ack = 1'b1;
        if (wr)
        begin
          r_next.con2 = wb_dat_i[7:0];
        end
      end
      else if (wb_adr_i == ssp_pkg::ADDR_SLAVE_ADDR)
      begin
        r_next.rdat[7:0] = r_reg.addr;
        r_next.ack = 1'b1;
        if (wr)
        begin
          r_next.addr = wb_dat_i[7:0];
        end
      end
      else if (wb_adr_i == ssp_pkg::ADDR_POWER)
      begin
        r_next.rdat[2:0] = {r_reg.irq_en, r_reg.irq_flag, r_reg.sleep};
        r_next.ack = 1'b1;
        if (wr)
        begin
          r_next.sleep = wb_dat_i[ssp_pkg::PWR_SLEEP];
          r_next.irq_en = wb_dat_i[ssp_pkg::PWR_IRQ_EN];
          if (!wb_dat_i[ssp_pkg::PWR_IRQ_FLAG])
          begin
            r_next.irq_flag = 1'b0;
          end
        end
      end
      else
      begin
        r_next.err = 1'b1;
      end
    end
    // Master clock toggles every other cycle; sleep freezes it.
    // No toggle once the eighth bit is in, so no stray edge trails a byte.
    if (master && busy && !r_reg.sleep && !shift_done)
    begin
      r_next.div = r_reg.div + ssp_pkg::DIV_ONE;
      if (r_reg.div == ssp_pkg::DIV_ONE)
      begin
        r_next.div = ssp_pkg::DIV_ZERO;
        r_next.sck = !r_reg.sck;
      end
    end
    else if (!busy)
    begin
      r_next.sck = r_reg.con1[ssp_pkg::CON1_CKP];
      r_next.div = ssp_pkg::DIV_ZERO;
    end
    // Present the next data bit on the launch edge.
    if (shift_edge || load)
    begin
      r_next.sdo = load ? wb_dat_i[7] : shift_data[7];
    end
    case (r_reg.st)
      SSP_IDLE:
      begin
        if (load || (slave && sample_edge))
        begin
          r_next.st = SSP_RUN;
        end
      end
      SSP_RUN:
      begin
        if (shift_done)
        begin
          r_next.st = SSP_DONE;
        end
      end
      SSP_DONE:
      begin
        // Completed byte moves to the buffer if it is empty; over an unread byte it is dropped and OVF is set.
        if (r_reg.bf)
        begin
          r_next.con1[ssp_pkg::CON1_OVF] = 1'b1;
        end
        else
        begin
          r_next.buf_q = shift_data;
        end
        r_next.bf = 1'b1;
        r_next.irq_flag = 1'b1;
        r_next.sck = r_reg.con1[ssp_pkg::CON1_CKP];
        r_next.st = SSP_IDLE;
      end
      default:
      begin
        r_next.st = SSP_IDLE;
      end
    endcase
    if (clr)
    begin
      r_next.st = SSP_IDLE;
    end
    // Wake only while the flag is enabled.
    r_next.wake = r_next.irq_flag && r_next.irq_en;
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  // Reset zeroes every control and status field.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r_reg <= '0;
      r_reg.st <= SSP_IDLE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o = r_reg.rdat;
  assign wb_ack_o = r_reg.ack;
  assign wb_err_o = r_reg.err;
  assign sck_o = r_reg.sck;
  assign sck_oe = r_reg.con1[ssp_pkg::CON1_EN] && !r_reg.con1[2];
  assign sdo_o = r_reg.sdo;
  assign wake_o = r_reg.wake;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  a_collision_set: assert property (@(posedge clk) disable iff (sys_rst)
    (wr && busy && wb_adr_i == 5'h00) |=> r_reg.con1[7])
    else $error("collision bit not set");
  a_buffer_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (rd && wb_adr_i == 5'h00 && r_reg.st != SSP_DONE) |=> !r_reg.bf)
    else $error("buffer full not cleared by read");
  a_done_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (r_reg.st == SSP_DONE && !clr) |=> (r_reg.bf && r_reg.irq_flag))
    else $error("byte completion did not set flag");
  a_flag_sticks: assert property (@(posedge clk) disable iff (sys_rst)
    (r_reg.irq_flag && !(wr && wb_adr_i == 5'h14)) |=> r_reg.irq_flag)
    else $error("flag dropped without software clear");
  a_wake_gated: assert property (@(posedge clk) disable iff (sys_rst)
    wake_o |-> $past(r_next.irq_en))
    else $error("wake without enable");
  a_sleep_freeze: assert property (@(posedge clk) disable iff (sys_rst)
    (master && r_reg.sleep && $past(r_reg.sleep)) |=> $stable(r_reg.sck))
    else $error("master clock moved in sleep");
  a_status_low_ro: assert property (@(posedge clk) disable iff (sys_rst)
    (wr && wb_adr_i == 5'h08 && r_reg.st == SSP_IDLE && !rd)
      |=> (r_reg.bf == $past(r_reg.bf)))
    else $error("read-only status bit written");
  a_idle_polarity: assert property (@(posedge clk) disable iff (sys_rst)
    (!busy && r_reg.st == SSP_IDLE) ##1 (r_reg.st == SSP_IDLE)
      |-> (r_reg.sck == $past(r_reg.con1[4])))
    else $error("idle clock level wrong");
  a_reset_clear: assert property (@(posedge clk)
    sys_rst |=> (r_reg.con1 == 8'h00 && r_reg.st == SSP_IDLE))
    else $error("reset did not clear control");
  c_master_byte: cover property (@(posedge clk) master ##1 r_reg.st == SSP_DONE);
  c_slave_byte: cover property (@(posedge clk) slave ##1 r_reg.st == SSP_DONE);
  c_collision: cover property (@(posedge clk) wr && busy);
  c_overflow: cover property (@(posedge clk) $rose(r_reg.con1[6]));
endmodule : ssp_core
`default_nettype wire

// ===== core/ssp_edge.sv
// Clock-edge selector that maps polarity and edge bits onto SPI edges.
`timescale 1ns/1ps
`default_nettype none
module ssp_edge (
  input wire logic sck_now,    // Present serial clock level.
  input wire logic sck_prev,   // Level one cycle earlier.
  input wire logic pol,        // Clock polarity (idle level).
  input wire logic cke,        // Edge select bit.
  output logic shift_edge,     // Edge that launches new data.
  output logic sample_edge     // Edge that latches data in.
);
  logic to_active;
  logic to_idle;
  // Active means away from the idle level; cke=1 shifts on active-to-idle.
  assign to_active = (sck_now != pol) && (sck_prev == pol);
  assign to_idle = (sck_now == pol) && (sck_prev != pol);
  assign shift_edge = cke ? to_idle : to_active;
  assign sample_edge = cke ? to_active : to_idle;
endmodule : ssp_edge
`default_nettype wire

// ===== core/ssp_pkg.sv
// Package of register map, field layout and encodings for the serial port.
package ssp_pkg;
  // ----------------------------------------------------------------------
  // Register word offsets (byte addresses on the bus).
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_BUFFER = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_ONE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_CONTROL_TWO = 4'hC;
  localparam logic [4:0] ADDR_SLAVE_ADDR = 5'h10;
  localparam logic [4:0] ADDR_POWER = 5'h14;
  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int CON1_WRITE_COLLISION = 7;
  localparam int CON1_OVF = 6;
  localparam int CON1_EN = 5;
  localparam int CON1_CKP = 4;
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_BF = 0;
  localparam int PWR_SLEEP = 0;
  localparam int PWR_IRQ_FLAG = 1;
  localparam int PWR_IRQ_EN = 2;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] STAT_RW_MASK = 8'hC0;
  localparam logic [6:0] BAUD_MASK = 7'h7F;
  localparam logic [3:0] MODE_SPI_MASTER = 4'h0;
  localparam logic [3:0] MODE_SPI_SLAVE = 4'h4;
  localparam logic [3:0] MODE_I2C_SLAVE = 4'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [1:0] DIV_ONE = 2'h1;
  localparam logic [1:0] DIV_ZERO = 2'h0;
endpackage : ssp_pkg

// ===== core/ssp_shift.sv
// Eight-bit shift register with bit counter used by master and slave.
`timescale 1ns/1ps
`default_nettype none
module ssp_shift (
  input wire logic clk,            // System clock.
  input wire logic clr,            // Abort and clear the bit counter.
  input wire logic load,           // Parallel load from buffer write.
  input wire logic [7:0] load_val, // Value loaded.
  input wire logic sample,         // Sample data input.
  input wire logic sdi,            // Serial data in.
  output logic [7:0] data,         // Shift register contents.
  output logic done                // Pulse when eighth bit is sampled.
);
  logic [2:0] cnt;
  // Counter wraps at eight bits; clr forces it back to zero.
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    if (clr)
    begin
      cnt <= ssp_pkg::BIT_ZERO;
    end
    else if (load)
    begin
      data <= load_val;
      cnt <= ssp_pkg::BIT_ZERO;
    end
    else if (sample)
    begin
      data <= {data[6:0], sdi};
      cnt <= cnt + 3'h1;
      done <= (cnt == ssp_pkg::BIT_LAST);
    end
  end
endmodule : ssp_shift
`default_nettype wire

// ===== verification/ssp_core_tb.sv
// Self-checking bench for the serial port core.
`timescale 1ns/1ps
`default_nettype none
module ssp_core_tb;
  localparam logic [4:0] A_BUF = {1'b0, ssp_pkg::ADDR_BUFFER};
  localparam logic [4:0] A_C1 = {1'b0, ssp_pkg::ADDR_CONTROL_ONE};
  localparam logic [4:0] A_ST = {1'b0, ssp_pkg::ADDR_STATUS};
  localparam logic [4:0] A_C2 = {1'b0, ssp_pkg::ADDR_CONTROL_TWO};
  localparam logic [4:0] A_SA = ssp_pkg::ADDR_SLAVE_ADDR;
  localparam logic [4:0] A_PW = ssp_pkg::ADDR_POWER;
  logic clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack_o, wb_err_o, err;
  logic sck_i, sck_o, sck_oe, sdi_i, sdo_o, ss_n_i, wake_o;
  logic [4:0] wb_adr;
  logic [3:0] wb_sel, sel_mask;
  logic [31:0] wb_dat, wb_dat_o;
  logic [7:0] rd, b;
  int failures, checked, i;
  // ----------------------------------------------------------------
  // Design and far-side model.
  // ----------------------------------------------------------------
  ssp_core u_ssp_core (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o),
    .ss_n_i(ss_n_i), .wake_o(wake_o));
  ssp_spi_partner u_ssp_spi_partner (.clk(clk), .sck_o(sck_o),
    .sdo_o(sdo_o), .sdi_i(sdi_i), .sck_i(sck_i), .ss_n_i(ss_n_i));
  // Free-running 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Print the counts and the verdict, then stop.
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("Error at %0t ns: got 0x%h, expected 0x%h", $time, got, exp);
      failures++;
    end
  endtask : chk
  // One classic cycle; ack is sampled on the rising edge, data taken there.
  task automatic bus(input logic we, input logic [4:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= sel_mask;
    wb_adr <= a;
    wb_dat <= {24'h000000, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        $display("Error at %0t ns: ack wait 0x%h, limit 0x%h", $time, n, 50);
        failures++;
        wrap_up;
      end
      @(posedge clk);
    end
    rd = wb_dat_o[7:0];
    err = wb_err_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rc
  // Poll the status register until a received byte is reported.
  task automatic wait_bf;
    int n;
    n = 0;
    rd = 8'h00;
    while (rd[ssp_pkg::STAT_BF] !== 1'b1)
    begin
      n++;
      if (n > 200)
      begin
        $display("Error at %0t ns: poll count 0x%h, limit 0x%h", $time, n, 200);
        failures++;
        wrap_up;
      end
      bus(1'b0, A_ST, 8'h00);
    end
  endtask : wait_bf
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    checked = 0;
    sys_rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 5'h00;
    wb_sel = 4'hF;
    sel_mask = 4'hF;
    wb_dat = 32'h00000000;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rc(A_C1, 8'h00);
    rc(A_ST, 8'h00);
    rc(A_C2, 8'h00);
    rc(A_SA, 8'h00);
    rc(A_PW, 8'h00);
    wr(A_C1, 8'hC6);
    rc(A_C1, 8'hC6);
    wr(A_C1, 8'h00);
    wr(A_C2, 8'hA5);
    rc(A_C2, 8'hA5);
    wr(A_SA, 8'h5A);
    rc(A_SA, 8'h5A);
    // Two-wire mode leaves the clock pin undriven, as an input.
    wr(A_C1, {4'h2, ssp_pkg::MODE_I2C_SLAVE});
    chk({7'h00, sck_oe}, 8'h00);
    wr(A_C1, 8'h00);
    // A write with byte lane zero off must leave the register alone.
    sel_mask = 4'h0;
    wr(A_C2, 8'h3C);
    sel_mask = 4'hF;
    rc(A_C2, 8'hA5);
    wr(A_ST, 8'hFF);
    rc(A_ST, ssp_pkg::STAT_RW_MASK);
    bus(1'b0, 5'h18, 8'h00);
    chk({7'h00, err}, 8'h01);
    // Master transfer in each of the four standard modes.
    for (i = 0; i < 4; i++)
    begin
      b = 8'h3C + 8'(i * 17);
      wr(A_ST, {1'b0, ~i[0], 6'h00});
      wr(A_PW, {5'h00, i[0], 2'b00});
      wr(A_C1, {3'b001, i[1], 4'h0});
      repeat (2) @(negedge clk);
      chk({7'h00, sck_o}, {7'h00, i[1]});
      u_ssp_spi_partner.arm(~b, i[1], ~i[0]);
      wr(A_BUF, b);
      wait_bf;
      chk(u_ssp_spi_partner.rx, b);
      chk({7'h00, wake_o}, {7'h00, i[0]});
      rc(A_PW, {5'h00, i[0], 2'b10});
      rc(A_BUF, ~b);
      rc(A_ST, {1'b0, ~i[0], 6'h00});
      wr(A_PW, 8'h00);
      wr(A_C1, 8'h00);
      @(negedge clk);
      chk({7'h00, wake_o}, 8'h00);
    end
    // Collision in mid-transfer, then sleep freezes the clock.
    wr(A_ST, 8'h40);
    wr(A_C1, 8'h20);
    u_ssp_spi_partner.arm(8'h96, 1'b0, 1'b1);
    wr(A_BUF, 8'h69);
    wr(A_BUF, 8'hFF);
    rc(A_C1, 8'hA0);
    wr(A_PW, 8'h01);
    @(negedge clk);
    b[0] = sck_o;
    for (i = 0; i < 20; i++)
    begin
      @(negedge clk);
      chk({7'h00, sck_o}, {7'h00, b[0]});
    end
    wr(A_PW, 8'h00);
    wait_bf;
    chk(u_ssp_spi_partner.rx, 8'h69);
    rc(A_BUF, 8'h96);
    wr(A_C1, 8'h20);
    rc(A_C1, 8'h20);
    // Slave receive while asleep wakes the processor.
    wr(A_C1, 8'h00);
    wr(A_C1, 8'h24);
    wr(A_PW, 8'h05);
    u_ssp_spi_partner.run_master(8'hA7);
    wait_bf;
    chk({7'h00, wake_o}, 8'h01);
    chk({7'h00, sck_oe}, 8'h00);
    rc(A_BUF, 8'hA7);
    wr(A_PW, 8'h00);
    wr(A_C1, 8'h20);
    // Reset in mid-transfer.
    u_ssp_spi_partner.arm(8'h11, 1'b0, 1'b1);
    wr(A_BUF, 8'h55);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({6'h00, sck_o, sck_oe}, 8'h00);
    repeat (40) @(posedge clk);
    rc(A_C1, 8'h00);
    rc(A_ST, 8'h00);
    wrap_up;
  end
endmodule : ssp_core_tb
`default_nettype wire

// ===== verification/ssp_spi_partner.sv
// Behavioural far-side SPI device for the serial port bench.
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_partner (
  input wire logic clk,   // System clock.
  input wire logic sck_o, // Clock from the port as master.
  input wire logic sdo_o, // Data from the port.
  output logic sdi_i,     // Data to the port.
  output logic sck_i,     // Clock to the port as slave.
  output logic ss_n_i     // Select to the port, active low.
);
  logic clock_polarity, cke, armed, driving, sck_q;
  logic [7:0] tx, rx;
  int nl, ns;
  // The slave clock rests at the idle level before the port is enabled.
  initial
  begin
    sck_i = 1'b0;
    ss_n_i = 1'b1;
    sdi_i = 1'b0;
    sck_q = 1'b0;
    armed = 1'b0;
    driving = 1'b0;
  end
  // Launch on one edge, sample on the other; a released line toggles
  // every cycle so a stale value can never pass for real data.
  always @(posedge clk)
  begin
    sck_q <= sck_o;
    if (!armed && !driving)
      sdi_i <= ~sdi_i;
    else if (armed && sck_o != sck_q)
    begin
      if ((sck_o != clock_polarity) == cke)
      begin
        rx <= {rx[6:0], sdo_o};
        ns <= ns + 1;
        armed <= (ns < 7);
      end
      else if (nl < (cke ? 7 : 8))
      begin
        sdi_i <= tx[(cke ? 6 : 7) - nl];
        nl <= nl + 1;
      end
    end
  end
  // Prepare one byte to answer a transfer started by the port.
  task automatic arm(input logic [7:0] b, input logic p, input logic e);
    tx = b;
    clock_polarity = p;
    cke = e;
    nl = 0;
    ns = 0;
    armed = 1'b1;
    sdi_i <= b[7];
  endtask : arm
  // Act as master: polarity 0, data sampled on the rising edge.
  task automatic run_master(input logic [7:0] b);
    driving = 1'b1;
    ss_n_i <= 1'b0;
    sdi_i <= b[7];
    for (int k = 7; k >= 0; k--)
    begin
      repeat (4) @(posedge clk);
      sck_i <= 1'b1;
      repeat (4) @(posedge clk);
      sck_i <= 1'b0;
      if (k > 0)
        sdi_i <= b[k - 1];
    end
    repeat (4) @(posedge clk);
    ss_n_i <= 1'b1;
    driving <= 1'b0;
  endtask : run_master
endmodule : ssp_spi_partner
`default_nettype wire
